// ===== core/clock_source_startup_select.sv
// module: clock source selection, start-up release and clock output
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_select
#(
	parameter logic [20:0] DELAY_4MS_CYCLES   =
		21'(clock_select_pkg::DELAY_4MS_CYCLES_DEF),
	parameter logic [20:0] DELAY_4P1MS_CYCLES =
		21'(clock_select_pkg::DELAY_4P1MS_CYCLES_DEF),
	parameter logic [20:0] DELAY_65MS_CYCLES  =
		21'(clock_select_pkg::DELAY_65MS_CYCLES_DEF),
	parameter logic [15:0] WAKE_LF_32K_CYCLES =
		16'(clock_select_pkg::WAKE_LF_32K_DEF)
)
(
	input  wire logic                              CLK,
	input  wire logic                              RST,
	input  wire logic [clock_select_pkg::SRC_W-1:0] CLOCK_SOURCE_FUSES,
	input  wire logic [1:0]                        STARTUP_DELAY_FUSES,
	input  wire logic                              CLOCK_OUTPUT_FUSE,
	input  wire logic                              CRYSTAL_PIN_ONE,
	input  wire logic                              POWER_DOWN,
	input  wire logic                              GPIO_OUT,
	input  wire logic                              GPIO_OE,
	input  wire logic                              HSEL,
	input  wire logic [31:0]                       HADDR,
	input  wire logic [1:0]                        HTRANS,
	input  wire logic                              HWRITE,
	input  wire logic [2:0]                        HSIZE,
	input  wire logic [31:0]                       HWDATA,
	input  wire logic                              HREADY,
	output var  logic [31:0]                       HRDATA,
	output var  logic                              HREADYOUT,
	output var  logic                              HRESP,
	output var  logic                              INTERNAL_RESET,
	output var  logic                              SYSTEM_CLOCK_ENABLE,
	output var  logic                              SYSTEM_CLOCK,
	output var  logic                              CLOCK_OUTPUT_PIN,
	output var  logic                              CLOCK_OUTPUT_PIN_OE,
	output var  logic                              CRYSTAL_AMP_ENABLE,
	output var  logic                              TIMER_OSC_TICK
);
	import clock_select_pkg::*;

	// ============================================================
	// types and state
	typedef enum logic [2:0]
	{
		M_CAPTURE, M_RESET_WAIT, M_RUN, M_SLEEP, M_WAKE_WAIT
	} mode_type;

	typedef enum logic [1:0] {SEL_RC, SEL_EXTERNAL, SEL_LOW_FREQ} source_type;

	typedef struct packed
	{
		mode_type              mode;
		source_type            source;
		logic [SRC_W-1:0]      src_code;
		logic [1:0]            sut_code;
		logic                  pin_one;
		logic [3:0]            rc_cnt;
		logic                  rc_phase;
		logic [8:0]            div_cnt;
		logic                  sys_clk;
		logic [PRESCALE_W-1:0] prescale;
		logic                  ext_input;
		logic                  timer_osc_req;
		logic                  wr_pend;
		logic [7:0]            wr_addr;
		logic [31:0]           hrdata;
		logic                  int_reset;
		logic                  clk_enable;
		logic                  clk_out;
		logic                  clk_out_oe;
		logic                  amp_enable;
		logic                  timer_tick;
	} clock_state_type;

	clock_state_type s_q;
	clock_state_type s_d;

	startup_timer_if tif ();

	startup_timer u_timer
	(
		.CLK (CLK),
		.RST (RST),
		.tif (tif)
	);

	// ============================================================
	// helpers
	function automatic logic [FIX_W-1:0] fixed_delay
	(
		input logic [1:0] startup_delay_fuses,
		input source_type src
	);
		logic [FIX_W-1:0] v;
		v = '0;
		case (startup_delay_fuses)
			SUT_MEDIUM:
			begin
				// low-frequency crystal uses 4 ms, the others 4.1 ms
				if (src == SEL_LOW_FREQ)
				begin
					v = DELAY_4MS_CYCLES;
				end
				else
				begin
					v = DELAY_4P1MS_CYCLES;
				end
			end
			SUT_LONG:
			begin
				v = DELAY_65MS_CYCLES;
			end
			default:
			begin
				// short and reserved codes: source cycles only
				v = '0;
			end
		endcase
		return v;
	endfunction

	function automatic logic [CYC_W-1:0] wake_cycles
	(
		input logic [SRC_W-1:0] code,
		input source_type       src
	);
		logic [CYC_W-1:0] v;
		v = WAKE_SHORT_CYCLES;
		if (src == SEL_LOW_FREQ)
		begin
			if (code == SRC_LF_32K)
			begin
				v = WAKE_LF_32K_CYCLES;
			end
			else
			begin
				v = WAKE_LF_1K_CYCLES;
			end
		end
		return v;
	endfunction

	logic       src_half;
	logic       src_rise;
	logic       pin_rise;
	logic       pin_edge;
	logic       addr_phase;
	logic [8:0] div_limit;

	always_comb
	begin
		pin_rise   = CRYSTAL_PIN_ONE & ~s_q.pin_one;
		pin_edge   = CRYSTAL_PIN_ONE ^ s_q.pin_one;
		addr_phase = HSEL & HREADY & HTRANS[1];
		div_limit  = 9'((10'h001 << s_q.prescale) - 10'h001);
		if (s_q.source == SEL_RC)
		begin
			src_half = (s_q.rc_cnt == RC_HALF_CYCLES - 4'h1);
			src_rise = src_half & ~s_q.rc_phase;
		end
		else
		begin
			// both external and watch crystal enter on pin one
			src_half = pin_edge;
			src_rise = pin_rise;
		end
	end

	assign tif.src_tick = src_rise;

	// ============================================================
	// next state
	always_comb
	begin
		s_d            = s_q;
		s_d.pin_one    = CRYSTAL_PIN_ONE;
		tif.start        = 1'b0;
		tif.src_cycles   = RESET_SRC_CYCLES;
		tif.fixed_cycles = fixed_delay(s_q.sut_code, s_q.source);

		// internal RC stand-in
		if (src_half && s_q.source == SEL_RC)
		begin
			s_d.rc_cnt   = '0;
			s_d.rc_phase = ~s_q.rc_phase;
		end
		else if (s_q.source == SEL_RC)
		begin
			s_d.rc_cnt = s_q.rc_cnt + 4'h1;
		end

		// prescaled system clock toggles every 2^n source half periods
		if (src_half)
		begin
			if (s_q.div_cnt >= div_limit)
			begin
				s_d.div_cnt = '0;
				s_d.sys_clk = ~s_q.sys_clk;
			end
			else
			begin
				s_d.div_cnt = s_q.div_cnt + 9'h001;
			end
		end

		// start-up and sleep sequencing
		case (s_q.mode)
			M_CAPTURE:
			begin
				// fuses are sampled once, one cycle after reset release
				s_d.src_code = CLOCK_SOURCE_FUSES;
				s_d.sut_code = STARTUP_DELAY_FUSES;
				if (CLOCK_SOURCE_FUSES == SRC_EXTERNAL)
				begin
					s_d.source = SEL_EXTERNAL;
				end
				else if (CLOCK_SOURCE_FUSES == SRC_LF_1K ||
				         CLOCK_SOURCE_FUSES == SRC_LF_32K)
				begin
					s_d.source = SEL_LOW_FREQ;
				end
				else
				begin
					s_d.source = SEL_RC;
				end
				s_d.mode = M_RESET_WAIT;
			end
			M_RESET_WAIT:
			begin
				// start once: a restart on done would leave the timer
				// busy and make it refuse the later wake-up request
				tif.start = ~tif.busy & ~tif.done;
				if (tif.done)
				begin
					s_d.int_reset = 1'b0;
					s_d.mode      = M_RUN;
				end
			end
			M_RUN:
			begin
				if (POWER_DOWN)
				begin
					s_d.mode = M_SLEEP;
				end
			end
			M_SLEEP:
			begin
				if (!POWER_DOWN)
				begin
					tif.start        = 1'b1;
					tif.src_cycles   = wake_cycles(s_q.src_code, s_q.source);
					tif.fixed_cycles = '0;
					s_d.mode         = M_WAKE_WAIT;
				end
			end
			M_WAKE_WAIT:
			begin
				tif.src_cycles   = wake_cycles(s_q.src_code, s_q.source);
				tif.fixed_cycles = '0;
				if (tif.done)
				begin
					s_d.mode = M_RUN;
				end
			end
			default:
			begin
				s_d.mode = M_CAPTURE;
			end
		endcase
		s_d.clk_enable = (s_d.mode == M_RUN);

		// register bus: write lands in the data phase
		if (s_q.wr_pend)
		begin
			case (s_q.wr_addr)
				ADDR_ASYNC_STATUS:
				begin
					s_d.ext_input     = HWDATA[ASYNC_EXT_INPUT_BIT];
					s_d.timer_osc_req = HWDATA[ASYNC_TIMER_OSC_BIT];
				end
				ADDR_PRESCALE:
				begin
					// reserved division codes are refused
					if (HWDATA[3:0] <= PRESCALE_MAX)
					begin
						s_d.prescale = HWDATA[3:0];
					end
				end
				default:
				begin
					s_d.prescale = s_d.prescale;
				end
			endcase
		end
		s_d.wr_pend = addr_phase & HWRITE & (HADDR[31:8] == 24'h000000);
		s_d.wr_addr = HADDR[7:0];

		// read data built from the updated values, so a read right
		// behind a write sees the new contents
		s_d.hrdata = 32'h00000000;
		if (addr_phase && !HWRITE && HADDR[31:8] == 24'h000000)
		begin
			case (HADDR[7:0])
				ADDR_ASYNC_STATUS:
				begin
					s_d.hrdata[ASYNC_EXT_INPUT_BIT] = s_d.ext_input;
					s_d.hrdata[ASYNC_TIMER_OSC_BIT] = s_d.timer_osc_req;
				end
				ADDR_PRESCALE:
				begin
					s_d.hrdata[PRESCALE_W-1:0] = s_d.prescale;
				end
				ADDR_CLOCK_STATUS:
				begin
					s_d.hrdata[STAT_TIMER_OSC_BIT] = s_q.amp_enable &
						(s_q.source == SEL_RC);
					s_d.hrdata[STAT_RUN_BIT]   = (s_q.mode == M_RUN);
					s_d.hrdata[STAT_SLEEP_BIT] = (s_q.mode == M_SLEEP);
					s_d.hrdata[STAT_SUT_LSB +: 2]     = s_q.sut_code;
					s_d.hrdata[STAT_SRC_LSB +: SRC_W] = s_q.src_code;
				end
				default:
				begin
					s_d.hrdata = 32'h00000000;
				end
			endcase
		end

		// timer oscillator: only beside the RC source, the pin is free
		// then; the crystal amplifier is off when pin one is driven
		s_d.timer_tick = 1'b0;
		s_d.amp_enable = 1'b0;
		if (s_q.source == SEL_LOW_FREQ)
		begin
			s_d.amp_enable = 1'b1;
		end
		else if (s_q.source == SEL_RC && s_q.timer_osc_req)
		begin
			s_d.amp_enable = ~s_q.ext_input;
			s_d.timer_tick = pin_rise;
		end

		// clock output overrides the port function outside reset; reset clears pin and enable
		if (CLOCK_OUTPUT_FUSE)
		begin
			s_d.clk_out    = s_d.sys_clk;
			s_d.clk_out_oe = 1'b1;
		end
		else
		begin
			s_d.clk_out    = GPIO_OUT;
			s_d.clk_out_oe = GPIO_OE;
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			s_q <= '{mode: M_CAPTURE, source: SEL_RC,
			         src_code: SRC_RC, prescale: PRESCALE_RESET,
			         int_reset: 1'b1, default: '0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// outputs
	assign HRDATA              = s_q.hrdata;
	assign HREADYOUT           = 1'b1;
	assign HRESP               = 1'b0;
	assign INTERNAL_RESET      = s_q.int_reset;
	assign SYSTEM_CLOCK_ENABLE = s_q.clk_enable;
	assign SYSTEM_CLOCK        = s_q.sys_clk;
	assign CLOCK_OUTPUT_PIN    = s_q.clk_out;
	assign CLOCK_OUTPUT_PIN_OE = s_q.clk_out_oe;
	assign CRYSTAL_AMP_ENABLE  = s_q.amp_enable;
	assign TIMER_OSC_TICK      = s_q.timer_tick;
endmodule
`default_nettype wire

// ===== core/startup_timer.sv
// module: counts source cycles, then a fixed number of system cycles
`timescale 1ns/1ps
`default_nettype none
module startup_timer
(
	input  wire logic     CLK,
	input  wire logic     RST,
	startup_timer_if.timer tif
);
	import clock_select_pkg::*;

	// ============================================================
	// state
	typedef enum logic [1:0] {T_IDLE, T_SOURCE, T_FIXED} phase_type;
	typedef struct packed
	{
		phase_type        phase;
		logic [CYC_W-1:0] src_cnt;
		logic [FIX_W-1:0] fix_cnt;
		logic [FIX_W-1:0] fix_target;
		logic             done;
	} timer_state_type;

	timer_state_type s_q;
	timer_state_type s_d;

	assign tif.busy = (s_q.phase != T_IDLE);
	assign tif.done = s_q.done;

	// ============================================================
	// sequencing
	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		case (s_q.phase)
			T_IDLE:
			begin
				if (tif.start)
				begin
					s_d.src_cnt    = '0;
					s_d.fix_cnt    = '0;
					s_d.fix_target = tif.fixed_cycles;
					s_d.phase      = T_SOURCE;
				end
			end
			T_SOURCE:
			begin
				// oscillator cycles come first, the time-out after them
				if (tif.src_tick)
				begin
					s_d.src_cnt = s_q.src_cnt + 16'h0001;
					if (s_q.src_cnt + 16'h0001 >= tif.src_cycles)
					begin
						if (s_q.fix_target == '0)
						begin
							s_d.phase = T_IDLE;
							s_d.done  = 1'b1;
						end
						else
						begin
							s_d.phase = T_FIXED;
						end
					end
				end
			end
			T_FIXED:
			begin
				s_d.fix_cnt = s_q.fix_cnt + 21'h000001;
				if (s_q.fix_cnt + 21'h000001 >= s_q.fix_target)
				begin
					s_d.phase = T_IDLE;
					s_d.done  = 1'b1;
				end
			end
			default:
			begin
				s_d.phase = T_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			s_q <= '{phase: T_IDLE, default: '0};
		end
		else
		begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// ===== inc/clock_select_pkg.sv
// package: constants of the clock source and start-up block
package clock_select_pkg;
	// ============================================================
	// fuse codes
	localparam int          SRC_W         = 4;
	localparam logic [3:0]  SRC_EXTERNAL  = 4'h0;
	localparam logic [3:0]  SRC_RC        = 4'h2;
	localparam logic [3:0]  SRC_LF_1K     = 4'h6;
	localparam logic [3:0]  SRC_LF_32K    = 4'h7;
	localparam logic [1:0]  SUT_SHORT     = 2'h0;
	localparam logic [1:0]  SUT_MEDIUM    = 2'h1;
	localparam logic [1:0]  SUT_LONG      = 2'h2;
	// ============================================================
	// timing
	localparam int CLK_FREQ_MHZ    = 20;
	localparam int DELAY_4MS_US    = 4000;
	localparam int DELAY_4P1MS_US  = 4100;
	localparam int DELAY_65MS_US   = 65000;
	localparam int DELAY_4MS_CYCLES_DEF   = DELAY_4MS_US * CLK_FREQ_MHZ;
	localparam int DELAY_4P1MS_CYCLES_DEF = DELAY_4P1MS_US * CLK_FREQ_MHZ;
	localparam int DELAY_65MS_CYCLES_DEF  = DELAY_65MS_US * CLK_FREQ_MHZ;
	localparam int CYC_W = 16;
	localparam int FIX_W = 21;
	localparam logic [15:0] RESET_SRC_CYCLES = 16'h000E;
	localparam logic [15:0] WAKE_SHORT_CYCLES = 16'h0006;
	localparam logic [15:0] WAKE_LF_1K_CYCLES = 16'h0400;
	localparam int          WAKE_LF_32K_DEF   = 32768;
	// stand-in for the internal RC: half period in system clock cycles
	localparam logic [3:0]  RC_HALF_CYCLES    = 4'h3;
	// ============================================================
	// register map
	localparam logic [7:0]  ADDR_ASYNC_STATUS = 8'h00;
	localparam logic [7:0]  ADDR_PRESCALE     = 8'h04;
	localparam logic [7:0]  ADDR_CLOCK_STATUS = 8'h08;
	localparam int          ASYNC_EXT_INPUT_BIT = 0;
	localparam int          ASYNC_TIMER_OSC_BIT = 1;
	localparam int          PRESCALE_W          = 4;
	localparam logic [3:0]  PRESCALE_RESET      = 4'h0;
	localparam logic [3:0]  PRESCALE_MAX        = 4'h8;
	localparam int          STAT_TIMER_OSC_BIT  = 0;
	localparam int          STAT_RUN_BIT        = 1;
	localparam int          STAT_SLEEP_BIT      = 2;
	localparam int          STAT_SUT_LSB        = 4;
	localparam int          STAT_SRC_LSB        = 8;
	localparam logic [1:0]  HTRANS_IDLE         = 2'h0;
	localparam logic [1:0]  HTRANS_NONSEQ       = 2'h2;
endpackage

// ===== inc/startup_timer_if.sv
// interface: start-up timer request and completion
`timescale 1ns/1ps
`default_nettype none
interface startup_timer_if;
	import clock_select_pkg::*;
	logic             start;
	logic [CYC_W-1:0] src_cycles;
	logic [FIX_W-1:0] fixed_cycles;
	logic             src_tick;
	logic             busy;
	logic             done;
	modport ctrl  (output start, src_cycles, fixed_cycles, src_tick,
	               input busy, done);
	modport timer (input start, src_cycles, fixed_cycles, src_tick,
	               output busy, done);
endinterface
`default_nettype wire

// ===== sim/clock_source_startup_select_properties.sv
// checker: timing relations at the ports of the clock source block
`timescale 1ns/1ps
`default_nettype none
module clock_select_checker
	import clock_select_pkg::*;
(
	input wire logic             CLK,
	input wire logic             RST,
	input wire logic [SRC_W-1:0] CLOCK_SOURCE_FUSES,
	input wire logic             CLOCK_OUTPUT_FUSE,
	input wire logic             POWER_DOWN,
	input wire logic             GPIO_OUT,
	input wire logic             GPIO_OE,
	input wire logic             INTERNAL_RESET,
	input wire logic             SYSTEM_CLOCK_ENABLE,
	input wire logic             SYSTEM_CLOCK,
	input wire logic             CLOCK_OUTPUT_PIN,
	input wire logic             CLOCK_OUTPUT_PIN_OE,
	input wire logic             CRYSTAL_AMP_ENABLE,
	input wire logic             TIMER_OSC_TICK
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// ==========================================================
	// sequences
	sequence sleep_req;
		SYSTEM_CLOCK_ENABLE && POWER_DOWN;
	endsequence
	sequence wake_req;
		$fell(POWER_DOWN) && !SYSTEM_CLOCK_ENABLE && !INTERNAL_RESET;
	endsequence
	// ==========================================================
	// properties
	AST_OUT_FUSE_OE: assert property (
		!$past(RST) && $past(CLOCK_OUTPUT_FUSE) |-> CLOCK_OUTPUT_PIN_OE)
		else $error("clock output pin not enabled with fuse set");
	AST_OUT_GPIO: assert property (
		!$past(RST) && !$past(CLOCK_OUTPUT_FUSE) |->
		CLOCK_OUTPUT_PIN_OE == $past(GPIO_OE) &&
		CLOCK_OUTPUT_PIN == $past(GPIO_OUT))
		else $error("clock output pin lost its port function");
	AST_OUT_FOLLOWS: assert property (
		!$past(RST) && $past(CLOCK_OUTPUT_FUSE) && CLOCK_OUTPUT_FUSE |->
		CLOCK_OUTPUT_PIN == SYSTEM_CLOCK ||
		CLOCK_OUTPUT_PIN == $past(SYSTEM_CLOCK))
		else $error("clock output pin differs from system clock");
	AST_HOLD_MIN: assert property (
		$fell(RST) |-> INTERNAL_RESET [*8])
		else $error("internal reset released too early");
	AST_RELEASE_LOW: assert property (
		!INTERNAL_RESET |=> !INTERNAL_RESET)
		else $error("internal reset came back without reset");
	AST_RELEASE_RUN: assert property (
		$fell(INTERNAL_RESET) |-> SYSTEM_CLOCK_ENABLE)
		else $error("clock not enabled at reset release");
	AST_SLEEP: assert property (
		sleep_req |-> ##[1:3] !SYSTEM_CLOCK_ENABLE)
		else $error("power-down did not stop the clock");
	AST_WAKE_MIN: assert property (
		wake_req |-> !SYSTEM_CLOCK_ENABLE [*6])
		else $error("wake-up shorter than six cycles");
	AST_TICK_RC: assert property (
		TIMER_OSC_TICK |-> CLOCK_SOURCE_FUSES == SRC_RC)
		else $error("timer tick without internal RC source");
	AST_TICK_PULSE: assert property (
		TIMER_OSC_TICK |=> !TIMER_OSC_TICK)
		else $error("timer tick longer than one cycle");
	AST_AMP_SRC: assert property (
		CRYSTAL_AMP_ENABLE |-> CLOCK_SOURCE_FUSES != SRC_EXTERNAL)
		else $error("crystal amplifier on with external clock");
endmodule
bind clock_source_startup_select clock_select_checker chk (
	.CLK(CLK), .RST(RST), .CLOCK_SOURCE_FUSES(CLOCK_SOURCE_FUSES),
	.CLOCK_OUTPUT_FUSE(CLOCK_OUTPUT_FUSE), .POWER_DOWN(POWER_DOWN),
	.GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
	.INTERNAL_RESET(INTERNAL_RESET),
	.SYSTEM_CLOCK_ENABLE(SYSTEM_CLOCK_ENABLE), .SYSTEM_CLOCK(SYSTEM_CLOCK),
	.CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN),
	.CLOCK_OUTPUT_PIN_OE(CLOCK_OUTPUT_PIN_OE),
	.CRYSTAL_AMP_ENABLE(CRYSTAL_AMP_ENABLE),
	.TIMER_OSC_TICK(TIMER_OSC_TICK));
`default_nettype wire

// ===== sim/clock_source_startup_select_tb.sv
// testbench: boot, wake-up, clock output, timer oscillator, registers
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_select_tb;
	import clock_select_pkg::*;
	logic        clk, rst, ofuse, pd, gout, goe, hsel, hwrite, pin1;
	logic        rdy, resp, irst, sce, sclk, opin, ooe, amp, tick;
	logic [3:0]  src;
	logic [1:0]  startup_delay_fuses, htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	int          n_errors, checks_done, seed, n, p;
	logic [3:0]  codes [4] = '{SRC_EXTERNAL, SRC_RC, SRC_LF_1K, SRC_LF_32K};
	// ==========================================================
	// design and far side
	clock_source_startup_select #(.DELAY_4MS_CYCLES(21'h28),
		.DELAY_4P1MS_CYCLES(21'h2D), .DELAY_65MS_CYCLES(21'h32),
		.WAKE_LF_32K_CYCLES(16'h28)) dut (
		.CLK(clk), .RST(rst), .CLOCK_SOURCE_FUSES(src),
		.STARTUP_DELAY_FUSES(startup_delay_fuses), .CLOCK_OUTPUT_FUSE(ofuse),
		.CRYSTAL_PIN_ONE(pin1), .POWER_DOWN(pd), .GPIO_OUT(gout),
		.GPIO_OE(goe), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(rdy),
		.HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(resp),
		.INTERNAL_RESET(irst), .SYSTEM_CLOCK_ENABLE(sce),
		.SYSTEM_CLOCK(sclk), .CLOCK_OUTPUT_PIN(opin),
		.CLOCK_OUTPUT_PIN_OE(ooe), .CRYSTAL_AMP_ENABLE(amp),
		.TIMER_OSC_TICK(tick));
	crystal_model #(.HALF(2)) xtal (.CLK(clk), .PIN(pin1));
	// ==========================================================
	// expectations and helpers
	function automatic int half(input logic [3:0] s);
		return (s == SRC_RC) ? 3 : 2;
	endfunction
	// s[2] marks the watch-crystal codes among those used here
	function automatic int boot_exp(input logic [3:0] s, input logic [1:0] u);
		int f;
		f = (u == SUT_MEDIUM) ? (s[2] ? 40 : 45) : (u == SUT_LONG) ? 50 : 0;
		return 28 * half(s) + f;
	endfunction
	function automatic int wake(input logic [3:0] s);
		return 2 * half(s) * ((s == SRC_LF_1K) ? 1024 :
			(s == SRC_LF_32K) ? 40 : 6);
	endfunction
	task automatic stop_test(input logic hung);
		if (hung)
			n_errors++;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// source edges are not phase-locked to the count start
	task automatic near(input int g, input int e, input int h);
		check((g >= e - 2 * h && g <= e + 10) ? e : g, e);
	endtask
	task automatic wait_for(ref logic sig, input logic lvl);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (sig !== lvl && n < 5000);
		if (n == 5000)
			stop_test(1'b1);
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'h2;
		wait_for(rdy, 1'b1);
		htrans <= HTRANS_IDLE;
		hsel <= 1'b0;
		hwdata <= d;
		wait_for(rdy, 1'b1);
		r = hrdata;
	endtask
	// ==========================================================
	// stimulus
	initial
	begin
		clk = 1'b0;
		forever
			#25 clk = ~clk;
	end
	initial
	begin
		seed = 52570;
		n_errors = 0;
		checks_done = 0;
		{rst, ofuse, pd, gout, goe, hsel, hwrite} = 7'h40;
		{src, startup_delay_fuses, htrans, hsize, haddr, hwdata} = '0;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk);
			rst <= 1'b1;
			src <= codes[i / 4];
			startup_delay_fuses <= 2'(i);
			ofuse <= (i % 4 == 0) | 1'($random(seed));
			gout <= 1'($random(seed));
			goe <= 1'($random(seed));
			repeat (10) @(posedge clk);
			rst <= 1'b0;
			wait_for(irst, 1'b0);
			near(n, boot_exp(src, startup_delay_fuses), half(src));
			check(ooe, ofuse | goe);
			if (!ofuse)
				check(opin, gout);
			check(amp, src[2]);
			bus(1'b0, ADDR_CLOCK_STATUS, '0);
			check(r, {src, 2'h0, startup_delay_fuses, 4'h2});
			check(resp, 1'b0);
			if (startup_delay_fuses == SUT_SHORT)
			begin
				bus(1'b0, ADDR_ASYNC_STATUS, '0);
				check(r, 32'h0);
				bus(1'b1, 8'h0C, 32'hFFFFFFFF);
				bus(1'b0, 8'h0C, '0);
				check(r, 32'h0);
				bus(1'b1, ADDR_ASYNC_STATUS, 32'h2);
				repeat (3) @(posedge clk);
				check(amp, src[2] | (src == SRC_RC));
				bus(1'b0, ADDR_CLOCK_STATUS, '0);
				check(r[0], src == SRC_RC);
				n = 0;
				repeat (48)
				begin
					@(posedge clk);
					n += int'(tick === 1'b1);
				end
				check(n, (src == SRC_RC) ? 12 : 0);
				bus(1'b1, ADDR_ASYNC_STATUS, 32'h3);
				repeat (3) @(posedge clk);
				check(amp, src[2]);
				p = $random(seed) & 3;
				bus(1'b1, ADDR_PRESCALE, p);
				bus(1'b1, ADDR_PRESCALE, 32'h9);
				bus(1'b0, ADDR_PRESCALE, '0);
				check(r, p);
				repeat (3) wait_for(opin, !opin);
				check(n, half(src) << p);
			end
			pd <= 1'b1;
			wait_for(sce, 1'b0);
			bus(1'b0, ADDR_CLOCK_STATUS, '0);
			check(r, {src, 2'h0, startup_delay_fuses, 4'h4});
			repeat (4) @(posedge clk);
			pd <= 1'b0;
			wait_for(sce, 1'b1);
			near(n, wake(src), half(src));
		end
		stop_test(1'b0);
	end
endmodule
`default_nettype wire

// ===== sim/crystal_model.sv
// model: free-running crystal or external clock on pin one
`timescale 1ns/1ps
`default_nettype none
module crystal_model
#(
	parameter int HALF = 2
)
(
	input  wire logic CLK,
	output var  logic PIN
);
	// ==========================================================
	// oscillator
	int cnt = 0;
	initial PIN = 1'b0;
	// fixed period: a crystal runs free, so no cycle-to-cycle step
	always @(posedge CLK)
	begin
		cnt = (cnt + 1) % HALF;
		if (cnt == 0)
			PIN <= !PIN;
	end
endmodule
`default_nettype wire
